// ===== src/fmsp_serial_port.sv
// four-mode serial port: synchronous shift and three async modes
`timescale 1ns/100ps
`include "fmsp_regs.svh"

module fmsp_serial_port (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [1:0] MODE_SELECT_BITS,
  input wire logic MULTIPROC_ENABLE,
  input wire logic RECEIVE_ENABLE_BIT,
  input wire logic TX_NINTH_BIT,
  input wire logic BAUD_DOUBLER,
  input wire logic RX_TIMER2_SELECT,
  input wire logic TX_TIMER2_SELECT,
  input wire logic TIMER2_EXT_CLOCK_SELECT,
  input wire logic TIMER2_EXT_PIN,
  input wire logic [15:0] TIMER2_RELOAD,
  input wire logic [7:0] TIMER1_RELOAD,
  input wire logic SERIAL_INT_ENABLE,
  input wire logic BUF_WRITE,
  input wire logic [7:0] BUF_WDATA,
  output logic [7:0] BUF_RDATA,
  input wire logic TX_FLAG_CLEAR,
  input wire logic RX_FLAG_CLEAR,
  output logic TX_DONE_FLAG,
  output logic RX_DONE_FLAG,
  output logic RX_NINTH_BIT,
  output logic SERIAL_IRQ,
  output logic TIMER2_IRQ_BLOCK,
  output logic TX_BUSY,
  output logic TX_PIN_O,
  input wire logic RX_PIN_I,
  output logic RX_PIN_O,
  output logic RX_PIN_OE
);
  import fmsp_pkg::*;

  fmsp_mode_t mode;
  logic nine;
  logic tx_tick;
  logic rx_tick;
  logic t2_ovf;

  fmsp_state_t tx_st_q;
  logic [8:0] tx_sh_q;
  logic [3:0] tx_bit_q;
  logic [3:0] tx_ovs_q;
  logic tx_line_q;
  logic tx_set;

  fmsp_state_t rx_st_q;
  logic [8:0] rx_sh_q;
  logic [3:0] rx_bit_q;
  logic [3:0] rx_ovs_q;
  logic rx_prev_q;
  logic rx_set;
  logic [7:0] rx_data;
  logic rx_ninth;
  logic rx_accept;

  logic [3:0] sync_q;
  logic sync_run;
  logic sync_edge;
  logic sync_rise;
  logic m0_rx_go;

  logic [7:0] rx_buf_q;
  logic rb8_q;
  logic ti_q;
  logic ri_q;
  logic [3:0] nbits;

  // ****************************************
  // mode decode
  // ****************************************
  assign mode = fmsp_mode_t'(MODE_SELECT_BITS);
  assign nine = MODE_SELECT_BITS[1];
  assign nbits = nine ? `FMSP_BITS9 : `FMSP_BITS8;

  // ****************************************
  // baud sources
  // ****************************************
  fmsp_timer2 u_timer2 (
    .clk(CLK),
    .rst(RST),
    .run(RX_TIMER2_SELECT | TX_TIMER2_SELECT),
    .ext_sel(TIMER2_EXT_CLOCK_SELECT),
    .ext_pin(TIMER2_EXT_PIN),
    .reload(TIMER2_RELOAD),
    .overflow(t2_ovf),
    .irq_block(TIMER2_IRQ_BLOCK)
  );

  fmsp_baud u_baud (
    .clk(CLK),
    .rst(RST),
    .mode(mode),
    .baud_doubler(BAUD_DOUBLER),
    .timer1_reload(TIMER1_RELOAD),
    .t2_overflow(t2_ovf),
    .rx_t2_sel(RX_TIMER2_SELECT),
    .tx_t2_sel(TX_TIMER2_SELECT),
    .tx_tick(tx_tick),
    .rx_tick(rx_tick)
  );

  // ****************************************
  // synchronous mode bit clock
  // ****************************************
  assign sync_run = (mode == MD_SYNC) &&
                    (tx_st_q != ST_IDLE || rx_st_q != ST_IDLE);
  assign sync_edge = sync_run && (sync_q == `FMSP_SYNC_LAST);
  assign sync_rise = sync_run && (sync_q == `FMSP_SYNC_RISE);
  assign m0_rx_go = (mode == MD_SYNC) && RECEIVE_ENABLE_BIT && !ri_q &&
                    tx_st_q == ST_IDLE && rx_st_q == ST_IDLE;

  always_ff @(posedge CLK) begin
    if (RST || !sync_run) begin
      sync_q <= 4'h0;
    end else if (sync_q == `FMSP_SYNC_LAST) begin
      sync_q <= 4'h0;
    end else begin
      sync_q <= sync_q + 4'h1;
    end
  end

  // ****************************************
  // transmitter
  // ****************************************
  always_ff @(posedge CLK) begin
    tx_set <= 1'b0;
    if (RST) begin
      tx_st_q <= ST_IDLE;
      tx_sh_q <= 9'h000;
      tx_bit_q <= 4'h0;
      tx_ovs_q <= 4'h0;
      tx_line_q <= 1'b1;
    end else if (mode == MD_SYNC) begin
      tx_line_q <= 1'b1;
      tx_ovs_q <= 4'h0;
      case (tx_st_q)
        ST_IDLE: begin
          if (BUF_WRITE && rx_st_q == ST_IDLE) begin
            tx_sh_q <= {1'b0, BUF_WDATA};
            tx_bit_q <= 4'h0;
            tx_st_q <= ST_BITS;
          end
        end
        ST_BITS: begin
          if (sync_edge) begin
            tx_sh_q <= {1'b0, tx_sh_q[8:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q == `FMSP_SYNC_BITS - 4'h1) begin
              tx_set <= 1'b1;
              tx_st_q <= ST_IDLE;
            end
          end
        end
        default: begin
          tx_st_q <= ST_IDLE;
        end
      endcase
    end else begin
      case (tx_st_q)
        ST_IDLE: begin
          tx_line_q <= 1'b1;
          if (BUF_WRITE) begin
            tx_sh_q <= {TX_NINTH_BIT, BUF_WDATA};
            tx_bit_q <= 4'h0;
            tx_ovs_q <= 4'h0;
            tx_line_q <= 1'b0;
            tx_st_q <= ST_START;
          end
        end
        ST_START: begin
          if (tx_tick) begin
            tx_ovs_q <= tx_ovs_q + 4'h1;
            if (tx_ovs_q == 4'hF) begin
              tx_line_q <= tx_sh_q[0];
              tx_st_q <= ST_BITS;
            end
          end
        end
        ST_BITS: begin
          if (tx_tick) begin
            tx_ovs_q <= tx_ovs_q + 4'h1;
            if (tx_ovs_q == 4'hF) begin
              tx_bit_q <= tx_bit_q + 4'h1;
              if (tx_bit_q == nbits - 4'h1) begin
                tx_line_q <= 1'b1;
                tx_set <= 1'b1;
                tx_st_q <= ST_STOP;
              end else begin
                tx_line_q <= tx_sh_q[1];
                tx_sh_q <= {1'b0, tx_sh_q[8:1]};
              end
            end
          end
        end
        ST_STOP: begin
          if (tx_tick) begin
            tx_ovs_q <= tx_ovs_q + 4'h1;
            if (tx_ovs_q == 4'hF) begin
              tx_st_q <= ST_IDLE;
            end
          end
        end
        default: begin
          tx_st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // receiver
  // ****************************************
  always_ff @(posedge CLK) begin
    if (RST) begin
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= RX_PIN_I;
    end
  end

  always_ff @(posedge CLK) begin
    rx_set <= 1'b0;
    if (RST) begin
      rx_st_q <= ST_IDLE;
      rx_sh_q <= 9'h000;
      rx_bit_q <= 4'h0;
      rx_ovs_q <= 4'h0;
    end else if (mode == MD_SYNC) begin
      rx_ovs_q <= 4'h0;
      case (rx_st_q)
        ST_IDLE: begin
          if (m0_rx_go && !BUF_WRITE) begin
            rx_bit_q <= 4'h0;
            rx_st_q <= ST_BITS;
          end
        end
        ST_BITS: begin
          if (sync_rise) begin
            rx_sh_q <= {RX_PIN_I, rx_sh_q[8:1]};
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == `FMSP_SYNC_BITS - 4'h1) begin
              rx_st_q <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          rx_set <= 1'b1;
          rx_st_q <= ST_IDLE;
        end
        default: begin
          rx_st_q <= ST_IDLE;
        end
      endcase
    end else begin
      case (rx_st_q)
        ST_IDLE: begin
          if (RECEIVE_ENABLE_BIT && rx_prev_q && !RX_PIN_I) begin
            rx_ovs_q <= 4'h0;
            rx_bit_q <= 4'h0;
            rx_st_q <= ST_START;
          end
        end
        ST_START: begin
          if (rx_tick) begin
            rx_ovs_q <= rx_ovs_q + 4'h1;
            if (rx_ovs_q == `FMSP_OVS_MID) begin
              rx_st_q <= RX_PIN_I ? ST_IDLE : ST_BITS;
            end
          end
        end
        ST_BITS: begin
          if (rx_tick) begin
            rx_ovs_q <= rx_ovs_q + 4'h1;
            if (rx_ovs_q == `FMSP_OVS_MID) begin
              rx_sh_q <= {RX_PIN_I, rx_sh_q[8:1]};
              rx_bit_q <= rx_bit_q + 4'h1;
              if (rx_bit_q == nbits - 4'h1) begin
                rx_st_q <= ST_STOP;
              end
            end
          end
        end
        ST_STOP: begin
          if (rx_tick) begin
            rx_ovs_q <= rx_ovs_q + 4'h1;
            if (rx_ovs_q == `FMSP_OVS_MID) begin
              rx_set <= rx_accept;
              rx_st_q <= ST_IDLE;
            end
          end
        end
        default: begin
          rx_st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // frame acceptance
  // ****************************************
  always_comb begin
    if (mode == MD_SYNC) begin
      rx_data = rx_sh_q[8:1];
      rx_ninth = rb8_q;
      rx_accept = 1'b1;
    end else if (nine) begin
      rx_data = rx_sh_q[7:0];
      rx_ninth = rx_sh_q[8];
      rx_accept = !ri_q && (!MULTIPROC_ENABLE || rx_sh_q[8]);
    end else begin
      rx_data = rx_sh_q[8:1];
      rx_ninth = RX_PIN_I;
      rx_accept = !ri_q && (!MULTIPROC_ENABLE || RX_PIN_I);
    end
  end

  // ****************************************
  // holding register and flags
  // ****************************************
  always_ff @(posedge CLK) begin
    if (RST) begin
      rx_buf_q <= `FMSP_RST_BYTE;
      rb8_q <= 1'b0;
    end else if (rx_set) begin
      rx_buf_q <= rx_data;
      rb8_q <= rx_ninth;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ti_q <= 1'b0;
    end else if (tx_set) begin
      ti_q <= 1'b1;
    end else if (TX_FLAG_CLEAR) begin
      ti_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ri_q <= 1'b0;
    end else if (rx_set) begin
      ri_q <= 1'b1;
    end else if (RX_FLAG_CLEAR) begin
      ri_q <= 1'b0;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign BUF_RDATA = rx_buf_q;
  assign TX_DONE_FLAG = ti_q;
  assign RX_DONE_FLAG = ri_q;
  assign RX_NINTH_BIT = rb8_q;
  assign SERIAL_IRQ = SERIAL_INT_ENABLE & (ti_q | ri_q);
  assign TX_BUSY = (tx_st_q != ST_IDLE);

  // shift clock low first half of each bit
  assign TX_PIN_O = sync_run ? (sync_q >= `FMSP_SYNC_RISE)
                             : tx_line_q;
  assign RX_PIN_O = tx_sh_q[0];
  assign RX_PIN_OE = (mode == MD_SYNC) && (tx_st_q == ST_BITS);
endmodule

// ===== src/fmsp_regs.svh
// constants for the four-mode serial port
`ifndef FMSP_REGS_SVH
`define FMSP_REGS_SVH

// ****************************************
// synchronous mode timing
// ****************************************
`define FMSP_SYNC_DIV 4'hC
`define FMSP_SYNC_LAST 4'hB
`define FMSP_SYNC_RISE 4'h6
`define FMSP_SYNC_BITS 4'h8

// ****************************************
// asynchronous framing
// ****************************************
`define FMSP_OVS_MID 4'h7
`define FMSP_BITS8 4'h8
`define FMSP_BITS9 4'h9

// ****************************************
// baud sources
// ****************************************
`define FMSP_T1_TOP 8'hFF
`define FMSP_T2_TOP 16'hFFFF
`define FMSP_FIX_DIV_SLOW 2'h3
`define FMSP_FIX_DIV_FAST 2'h1

// ****************************************
// reset values
// ****************************************
`define FMSP_RST_BYTE 8'h00
`define FMSP_RST_T2 16'h0000

`endif

// ===== src/fmsp_pkg.sv
// types for the four-mode serial port
package fmsp_pkg;

  typedef enum logic [1:0] {
    MD_SYNC = 2'b00,
    MD_VAR8 = 2'b01,
    MD_FIX9 = 2'b10,
    MD_VAR9 = 2'b11
  } fmsp_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_BITS = 2'b10,
    ST_STOP = 2'b11
  } fmsp_state_t;

endpackage

// ===== src/fmsp_timer2.sv
// timer 2 in baud generator operation
`timescale 1ns/100ps
`include "fmsp_regs.svh"

module fmsp_timer2 (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic ext_sel,
  input wire logic ext_pin,
  input wire logic [15:0] reload,
  output logic overflow,
  output logic irq_block
);
  import fmsp_pkg::*;

  logic [15:0] cnt_q;
  logic half_q;
  logic pin_q;
  logic step;

  // ****************************************
  // count source: half system clock or pin edge
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      half_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      half_q <= ~half_q;
      pin_q <= ext_pin;
    end
  end

  assign step = run & (ext_sel ? (ext_pin & ~pin_q) : half_q);

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= `FMSP_RST_T2;
    end else if (!run) begin
      // preload so the first overflow comes one reload period after select
      cnt_q <= reload;
    end else if (step) begin
      if (cnt_q == `FMSP_T2_TOP) begin
        cnt_q <= reload;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  assign overflow = step & (cnt_q == `FMSP_T2_TOP);
  assign irq_block = run;
endmodule

// ===== src/fmsp_baud.sv
// oversampling tick generation for transmit and receive
`timescale 1ns/100ps
`include "fmsp_regs.svh"

module fmsp_baud (
  input wire logic clk,
  input wire logic rst,
  input wire fmsp_pkg::fmsp_mode_t mode,
  input wire logic baud_doubler,
  input wire logic [7:0] timer1_reload,
  input wire logic t2_overflow,
  input wire logic rx_t2_sel,
  input wire logic tx_t2_sel,
  output logic tx_tick,
  output logic rx_tick
);
  import fmsp_pkg::*;

  logic [7:0] t1_q;
  logic t1_ovf;
  logic t1_half_q;
  logic t1_tick;
  logic [1:0] fix_q;
  logic fix_tick;
  logic [1:0] fix_top;

  // ****************************************
  // timer 1, 8-bit auto-reload
  // ****************************************
  assign t1_ovf = (t1_q == `FMSP_T1_TOP);

  always_ff @(posedge clk) begin
    if (rst) begin
      t1_q <= `FMSP_RST_BYTE;
    end else if (t1_ovf) begin
      t1_q <= timer1_reload;
    end else begin
      t1_q <= t1_q + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      t1_half_q <= 1'b0;
    end else if (t1_ovf) begin
      t1_half_q <= ~t1_half_q;
    end
  end

  // 16 ticks per bit: /32 or /16 of overflow rate
  assign t1_tick = t1_ovf & (baud_doubler | t1_half_q);

  // ****************************************
  // fixed rate: system clock /64 or /32
  // ****************************************
  assign fix_top = baud_doubler ? `FMSP_FIX_DIV_FAST
                                : `FMSP_FIX_DIV_SLOW;

  always_ff @(posedge clk) begin
    if (rst) begin
      fix_q <= 2'h0;
    end else if (fix_q >= fix_top) begin
      fix_q <= 2'h0;
    end else begin
      fix_q <= fix_q + 2'h1;
    end
  end

  assign fix_tick = (fix_q >= fix_top);

  // ****************************************
  // independent source selection
  // ****************************************
  always_comb begin
    if (mode == MD_FIX9) begin
      tx_tick = fix_tick;
      rx_tick = fix_tick;
    end else begin
      tx_tick = tx_t2_sel ? t2_overflow : t1_tick;
      rx_tick = rx_t2_sel ? t2_overflow : t1_tick;
    end
  end
endmodule

// ===== bench/fmsp_serial_port_props.sv
// assertion checker for the four-mode serial port
`timescale 1ns/100ps
module fmsp_serial_port_chk (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [1:0] MODE_SELECT_BITS,
  input wire logic RX_TIMER2_SELECT,
  input wire logic TX_TIMER2_SELECT,
  input wire logic SERIAL_INT_ENABLE,
  input wire logic BUF_WRITE,
  input wire logic [7:0] BUF_RDATA,
  input wire logic TX_FLAG_CLEAR,
  input wire logic RX_FLAG_CLEAR,
  input wire logic TX_DONE_FLAG,
  input wire logic RX_DONE_FLAG,
  input wire logic RX_NINTH_BIT,
  input wire logic SERIAL_IRQ,
  input wire logic TIMER2_IRQ_BLOCK,
  input wire logic TX_BUSY,
  input wire logic TX_PIN_O,
  input wire logic RX_PIN_OE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  chk_irq_gate: assert property (
    SERIAL_IRQ == (SERIAL_INT_ENABLE && (TX_DONE_FLAG || RX_DONE_FLAG)))
    else $error("serial irq wrong");
  chk_tx_hold: assert property (
    TX_DONE_FLAG && !TX_FLAG_CLEAR |=> TX_DONE_FLAG)
    else $error("tx flag dropped");
  chk_rx_hold: assert property (
    RX_DONE_FLAG && !RX_FLAG_CLEAR |=> RX_DONE_FLAG)
    else $error("rx flag dropped");
  chk_t2_block: assert property (
    TIMER2_IRQ_BLOCK == (RX_TIMER2_SELECT || TX_TIMER2_SELECT))
    else $error("timer2 block wrong");
  chk_rdata_cause: assert property (
    $changed(BUF_RDATA) |-> $rose(RX_DONE_FLAG))
    else $error("rx data changed without accept");
  chk_ninth_cause: assert property (
    $changed(RX_NINTH_BIT) |-> $rose(RX_DONE_FLAG))
    else $error("rx ninth changed without accept");
  chk_tx_start: assert property (
    BUF_WRITE && !TX_BUSY && MODE_SELECT_BITS != 2'h0
    |=> TX_BUSY && !TX_PIN_O)
    else $error("async start bit missing");
  chk_stop_flag: assert property (
    $rose(TX_DONE_FLAG) && MODE_SELECT_BITS != 2'h0 |-> TX_PIN_O && TX_BUSY)
    else $error("tx flag not at stop start");
  chk_sync_clock: assert property (
    $rose(RX_PIN_OE) |-> !TX_PIN_O [*6] ##1 TX_PIN_O [*6])
    else $error("shift clock shape wrong");
  chk_sync_len: assert property (
    $rose(RX_PIN_OE) |-> ##95 RX_PIN_OE ##1 !RX_PIN_OE ##[1:2] TX_DONE_FLAG)
    else $error("sync frame length wrong");
  cover property ($rose(RX_PIN_OE));
  cover property ($rose(RX_DONE_FLAG) && MODE_SELECT_BITS == 2'h3);
  cover property ($rose(TX_DONE_FLAG) && MODE_SELECT_BITS == 2'h2);
endmodule
bind fmsp_serial_port fmsp_serial_port_chk u_chk (.CLK(CLK), .RST(RST),
  .MODE_SELECT_BITS(MODE_SELECT_BITS), .RX_TIMER2_SELECT(RX_TIMER2_SELECT),
  .TX_TIMER2_SELECT(TX_TIMER2_SELECT), .SERIAL_INT_ENABLE(SERIAL_INT_ENABLE),
  .BUF_WRITE(BUF_WRITE), .BUF_RDATA(BUF_RDATA),
  .TX_FLAG_CLEAR(TX_FLAG_CLEAR), .RX_FLAG_CLEAR(RX_FLAG_CLEAR),
  .TX_DONE_FLAG(TX_DONE_FLAG), .RX_DONE_FLAG(RX_DONE_FLAG),
  .RX_NINTH_BIT(RX_NINTH_BIT), .SERIAL_IRQ(SERIAL_IRQ),
  .TIMER2_IRQ_BLOCK(TIMER2_IRQ_BLOCK), .TX_BUSY(TX_BUSY),
  .TX_PIN_O(TX_PIN_O), .RX_PIN_OE(RX_PIN_OE));

// ===== bench/fmsp_peer.sv
// remote serial device model
`timescale 1ns/100ps
module fmsp_peer (
  input wire logic clk,
  input wire logic sclk,
  output logic line
);
  logic [7:0] sbyte;
  logic armed;
  logic seen_rise;
  int scnt;
  initial begin
    line = 1'b1;
    armed = 1'b0;
    seen_rise = 1'b0;
  end
  // ****************************************
  // asynchronous frame, line idles high
  // ****************************************
  task automatic send_async(input logic [7:0] d, input logic nine,
    input logic b9, input logic sb, input int bc);
    line = 1'b0;
    repeat (bc) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      line = d[i];
      repeat (bc) @(negedge clk);
    end
    if (nine) begin
      line = b9;
      repeat (bc) @(negedge clk);
    end
    line = sb;
    repeat (bc) @(negedge clk);
    line = 1'b1;
  endtask
  // ****************************************
  // synchronous slave: shifts on clock fall
  // ****************************************
  task automatic load_sync(input logic [7:0] d);
    sbyte = d;
    scnt = 0;
    seen_rise = 1'b0;
    armed = 1'b1;
    line = d[0];
  endtask
  always @(posedge sclk) if (armed) seen_rise = 1'b1;
  always @(negedge sclk) begin
    if (armed && seen_rise) begin
      scnt++;
      if (scnt == 8) begin
        armed = 1'b0;
        line = ~line;
      end else begin
        line = sbyte[scnt];
      end
    end
  end
endmodule

// ===== bench/fmsp_serial_port_bench.sv
// self-checking testbench for the four-mode serial port
`timescale 1ns/100ps
module fmsp_serial_port_bench;
  logic clk = 0, rst = 1, mp = 0, ren = 0, tx9 = 0, dbl = 0, ien = 1;
  logic rt2 = 0, tt2 = 0, bw = 0, tfc = 0, rfc = 0, t2x = 0, t2p = 0;
  logic [1:0] md = 0;
  logic [7:0] wd = 0, rd;
  logic tdf, rdf, r9, irq, t2b, busy, txo, rxo, rxoe, pl;
  wire rxw = rxoe ? rxo : pl;
  int n_fail = 0, n_tests = 0;
  always #4 clk = ~clk;
  // external timer 2 pin: one rising edge every two clocks
  always @(negedge clk) if (t2x) t2p = ~t2p;
  fmsp_serial_port u_dut (.CLK(clk), .RST(rst), .MODE_SELECT_BITS(md),
    .MULTIPROC_ENABLE(mp), .RECEIVE_ENABLE_BIT(ren), .TX_NINTH_BIT(tx9),
    .BAUD_DOUBLER(dbl), .RX_TIMER2_SELECT(rt2), .TX_TIMER2_SELECT(tt2),
    .TIMER2_EXT_CLOCK_SELECT(t2x), .TIMER2_EXT_PIN(t2p),
    .TIMER2_RELOAD(16'hFFFF), .TIMER1_RELOAD(8'hFE),
    .SERIAL_INT_ENABLE(ien), .BUF_WRITE(bw), .BUF_WDATA(wd),
    .BUF_RDATA(rd), .TX_FLAG_CLEAR(tfc), .RX_FLAG_CLEAR(rfc),
    .TX_DONE_FLAG(tdf), .RX_DONE_FLAG(rdf), .RX_NINTH_BIT(r9),
    .SERIAL_IRQ(irq), .TIMER2_IRQ_BLOCK(t2b), .TX_BUSY(busy),
    .TX_PIN_O(txo), .RX_PIN_I(rxw), .RX_PIN_O(rxo), .RX_PIN_OE(rxoe));
  fmsp_peer u_peer (.clk(clk), .sclk(txo), .line(pl));
  // ****************************************
  // helpers
  // ****************************************
  task chk(input string nm, input logic [8:0] s, input logic [8:0] e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task wbuf(input logic [7:0] d);
    wd = d;
    bw = 1;
    cyc(1);
    bw = 0;
  endtask
  task clr;
    tfc = 1;
    rfc = 1;
    cyc(1);
    tfc = 0;
    rfc = 0;
  endtask
  task wait_idle;
    int k;
    for (k = 0; k < 2000 && busy !== 1'b0; k++) cyc(1);
    if (busy !== 1'b0) begin
      n_fail++;
      final_report;
    end
  endtask
  task tx_async(input logic [1:0] m, input logic db, input logic t2,
    input int bc, input logic [7:0] d);
    int nb;
    md = m;
    dbl = db;
    tt2 = t2;
    tx9 = ~d[0];
    nb = m[1] ? 9 : 8;
    cyc(4);
    chk("t2 block", t2b, t2);
    wd = d;
    bw = 1;
    cyc(1);
    wd = ~d;
    cyc(1);
    bw = 0;
    cyc(bc / 2 - 2);
    chk("start", txo, 9'h000);
    for (int i = 0; i < nb; i++) begin
      cyc(bc);
      chk("tx bit", txo, i < 8 ? d[i] : tx9);
    end
    cyc(bc);
    chk("stop", txo, 9'h001);
    chk("tx flag", tdf, 9'h001);
    chk("irq", irq, 9'h001);
    wait_idle;
    chk("tx flag held", tdf, 9'h001);
    clr;
    chk("tx flag clear", tdf, 9'h000);
    tt2 = 0;
    $display("tx test mode %0d done", m);
  endtask
  task rx_async(input logic [1:0] m, input logic t2, input logic mpv,
    input logic [7:0] d, input logic b9, input logic sb,
    input logic ld, input logic ef);
    logic [7:0] od;
    logic o9;
    md = m;
    dbl = 1;
    rt2 = t2;
    mp = mpv;
    ren = 1;
    od = rd;
    o9 = r9;
    cyc(4);
    u_peer.send_async(d, m[1], b9, sb, 32);
    cyc(4);
    chk("rx flag", rdf, ef);
    chk("rx data", rd, ld ? d : od);
    chk("rx ninth", r9, ld ? (m[1] ? b9 : sb) : o9);
    rt2 = 0;
    $display("rx test mode %0d done", m);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int k;
    cyc(6);
    rst = 0;
    cyc(1);
    chk("reset busy", busy, 9'h000);
    chk("reset flags", {tdf, rdf}, 9'h000);
    chk("reset data", rd, 9'h000);
    chk("reset lines", {txo, rxoe}, 9'h002);
    // let timer 1 reach its first rollover before timing bits
    cyc(260);
    tx_async(2'h1, 1, 0, 32, 8'hA5);
    tx_async(2'h1, 0, 0, 64, 8'h3C);
    tx_async(2'h1, 0, 1, 32, 8'hC3);
    t2x = 1;
    tx_async(2'h1, 0, 1, 32, 8'h7E);
    t2x = 0;
    tx_async(2'h2, 0, 0, 64, 8'h5A);
    tx_async(2'h2, 1, 0, 32, 8'h96);
    tx_async(2'h3, 1, 0, 32, 8'h69);
    rx_async(2'h1, 0, 0, 8'hA5, 0, 1, 1, 1);
    ien = 0;
    cyc(1);
    chk("irq masked", irq, 9'h000);
    ien = 1;
    rx_async(2'h1, 0, 0, 8'h11, 0, 1, 0, 1);
    clr;
    rx_async(2'h1, 1, 1, 8'h22, 0, 0, 0, 0);
    rx_async(2'h3, 0, 1, 8'h33, 0, 1, 0, 0);
    rx_async(2'h3, 0, 1, 8'h44, 1, 0, 1, 1);
    clr;
    rx_async(2'h2, 0, 0, 8'h55, 0, 1, 1, 1);
    clr;
    ren = 0;
    mp = 0;
    md = 2'h0;
    cyc(4);
    wbuf(8'hB4);
    chk("sync oe", rxoe, 9'h001);
    for (int i = 0; i < 8; i++) begin
      cyc(i == 0 ? 6 : 12);
      chk("sync clock", txo, 9'h001);
      chk("sync bit", rxo, 8'hB4 >> i & 8'h01);
    end
    cyc(8);
    chk("sync end", {rxoe, tdf}, 9'h001);
    clr;
    u_peer.load_sync(8'h6D);
    ren = 1;
    for (k = 0; k < 300 && rdf !== 1'b1; k++) cyc(1);
    if (rdf !== 1'b1) begin
      n_fail++;
      final_report;
    end
    chk("sync rx flag", rdf, 9'h001);
    chk("sync rx data", rd, 9'h06D);
    cyc(30);
    chk("sync halted", {txo, rd}, 9'h16D);
    ren = 0;
    clr;
    $display("sync test done");
    final_report;
  end
endmodule
